// ---- logic/tcss_pkg.sv ----
// package for timer clock source selection: map, fields, divider counts, tick bundle
package tcss_pkg;
   // clock-control register, decoded on every special-function page
   localparam logic [7:0] TCSS_CLK_CTRL_ADDR = 8'h8e;
   localparam logic [7:0] TCSS_CLK_CTRL_RST = 8'h00;
   // field positions
   localparam int TCSS_PSEL_LSB = 0;
   localparam int TCSS_T0_SEL_BIT = 2;
   localparam int TCSS_T1_SEL_BIT = 3;
   localparam int TCSS_T2L_SEL_BIT = 4;
   localparam int TCSS_T2H_SEL_BIT = 5;
   localparam int TCSS_T3L_SEL_BIT = 6;
   localparam int TCSS_T3H_SEL_BIT = 7;
   // prescale select codes
   localparam logic [1:0] TCSS_PSEL_DIV12 = 2'h0;
   localparam logic [1:0] TCSS_PSEL_DIV4 = 2'h1;
   localparam logic [1:0] TCSS_PSEL_DIV48 = 2'h2;
   localparam logic [1:0] TCSS_PSEL_EXT8 = 2'h3;
   // divider terminal counts (divide ratio minus one) and the gap helper's saturation limit
   localparam logic [5:0] TCSS_DIV12_LAST = 6'h0b;
   localparam logic [5:0] TCSS_DIV4_LAST = 6'h03;
   localparam logic [5:0] TCSS_DIV48_LAST = 6'h2f;
   localparam logic [2:0] TCSS_EXT8_LAST = 3'h7;
   localparam logic [5:0] TCSS_GAP_MAX = 6'h3f;

   // one-cycle count enables handed to the timer cores
   typedef struct packed {
      logic tmr0;
      logic tmr1;
      logic tmr2_low;
      logic tmr2_high;
      logic tmr3_low;
      logic tmr3_high;
   } tcss_ticks_t;
endpackage

// ---- logic/tcss_edge_det.sv ----
// input synchroniser with combinational rise and fall detection from the registered samples
`timescale 1ns/1ps
module tcss_edge_det
   import tcss_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // sampled pin
   input wire logic pin,
   // one-cycle edge pulses
   output logic rise,
   output logic fall
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;

   // two stages before any use; first stage feeds only the second
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         sync1_r <= pin;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign fall = prev_r & ~sync2_r;
   assign rise = ~prev_r & sync2_r;

   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);

   fall_after_high_a: assert property (fall |-> !$past(pin, 2) && $past(pin, 3))
      else $error("fall pulse without high then low input samples");
   two_cycle_fall_a: assert property ($past(pin, 3) && !$past(pin, 2)
      && !$past(pin, 1) && !$past(rst, 3) |-> fall)
      else $error("held low level was not detected as a falling edge");
   quarter_rate_c: cover property (fall ##4 fall);
endmodule

// ---- logic/tcss_top.sv ----
// timer clock source selection: control register, prescaler and per-timer tick select
// Operation
// - prescaler divides system clock 12, 4, 48
// - code 11: external oscillator divided by eight
// - timer0 select bit: prescaler or system clock
// - timer0 counter mode ignores its select bit
// - timer1 select bit: prescaler or system clock
// - timer1 counter mode ignores its select bit
// - bit4: timer2 low byte clock choice
// - bit5: timer2 high byte, split mode only
// - bit6: timer3 low byte clock choice
// - bit7: timer3 high byte, split mode only
// - timers 2/3: system, div12, ext div8
// - counters advance once per falling input edge
// - counts events up to quarter clock rate
// - register decodes at 0x8E on every page
// - counter select makes timer0 count pin edges
`timescale 1ns/1ps
module tcss_top
   import tcss_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // special function register access
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // mode bits held in other timer registers
   input wire logic tmr0_counter_select,
   input wire logic tmr1_counter_select,
   input wire logic tmr2_ext_clock_option,
   input wire logic tmr3_ext_clock_option,
   input wire logic tmr2_split_mode,
   input wire logic tmr3_split_mode,
   // external pins
   input wire logic tmr0_event_pin,
   input wire logic tmr1_event_pin,
   input wire logic ext_osc_clk,
   // count enables
   output tcss_ticks_t ticks,
   output logic prescale_tick
);
   logic [7:0] timer_clock_control_r;
   logic [5:0] pre_cnt_r;
   logic [5:0] div12_cnt_r;
   logic [2:0] ext_cnt_r;
   logic ext_tick_r;
   logic div12_tick;
   logic pre_tick;
   logic [5:0] pre_last;
   logic fall0;
   logic fall1;
   logic ext_rise;
   logic reg_hit;
   logic [1:0] prescale_select;
   logic tmr0_clk_sel;
   logic tmr1_clk_sel;
   logic tmr2_low_byte_clk_sel;
   logic tmr2_high_byte_clk_sel;
   logic tmr3_low_byte_clk_sel;
   logic tmr3_high_byte_clk_sel;
   logic tmr2_opt_tick;
   logic tmr3_opt_tick;
   tcss_ticks_t ticks_r;
   logic prescale_tick_r;
   logic [7:0] rdata_r;

   // page input is deliberately unused in the decode
   assign reg_hit = (sfr_addr == TCSS_CLK_CTRL_ADDR);

   assign prescale_select = timer_clock_control_r[TCSS_PSEL_LSB +: 2];
   assign tmr0_clk_sel = timer_clock_control_r[TCSS_T0_SEL_BIT];
   assign tmr1_clk_sel = timer_clock_control_r[TCSS_T1_SEL_BIT];
   assign tmr2_low_byte_clk_sel = timer_clock_control_r[TCSS_T2L_SEL_BIT];
   assign tmr2_high_byte_clk_sel = timer_clock_control_r[TCSS_T2H_SEL_BIT];
   assign tmr3_low_byte_clk_sel = timer_clock_control_r[TCSS_T3L_SEL_BIT];
   assign tmr3_high_byte_clk_sel = timer_clock_control_r[TCSS_T3H_SEL_BIT];

   always_ff @(posedge mclk)
   begin
      if (rst)
         timer_clock_control_r <= TCSS_CLK_CTRL_RST;
      else if (sfr_wr && reg_hit)
         timer_clock_control_r <= sfr_wdata;
   end

   // registered read data; other addresses return zero
   always_ff @(posedge mclk)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else if (sfr_rd && reg_hit)
         rdata_r <= timer_clock_control_r;
      else
         rdata_r <= 8'h00;
   end
   assign sfr_rdata = rdata_r;

   // pin and oscillator sampling
   tcss_edge_det u_t0_pin (
      .mclk(mclk),
      .rst(rst),
      .pin(tmr0_event_pin),
      .rise(),
      .fall(fall0)
   );
   tcss_edge_det u_t1_pin (
      .mclk(mclk),
      .rst(rst),
      .pin(tmr1_event_pin),
      .rise(),
      .fall(fall1)
   );
   // oscillator must run below half the system clock to be seen
   tcss_edge_det u_ext_osc (
      .mclk(mclk),
      .rst(rst),
      .pin(ext_osc_clk),
      .rise(ext_rise),
      .fall()
   );

   // external oscillator divided by eight, already in the mclk domain
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ext_cnt_r <= 3'h0;
         ext_tick_r <= 1'b0;
      end
      else
      begin
         ext_tick_r <= ext_rise && (ext_cnt_r == TCSS_EXT8_LAST);
         if (ext_rise)
            ext_cnt_r <= ext_cnt_r + 3'h1;
      end
   end

   // free-running divide by twelve for timers 2 and 3
   assign div12_tick = (div12_cnt_r == TCSS_DIV12_LAST);
   always_ff @(posedge mclk)
   begin
      if (rst)
         div12_cnt_r <= 6'h00;
      else if (div12_tick)
         div12_cnt_r <= 6'h00;
      else
         div12_cnt_r <= div12_cnt_r + 6'h01;
   end

   // shared prescaler; >= compare recovers when a smaller ratio is chosen
   always_comb
   begin
      case (prescale_select)
         TCSS_PSEL_DIV12: pre_last = TCSS_DIV12_LAST;
         TCSS_PSEL_DIV4: pre_last = TCSS_DIV4_LAST;
         TCSS_PSEL_DIV48: pre_last = TCSS_DIV48_LAST;
         default: pre_last = TCSS_DIV12_LAST;
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
         pre_cnt_r <= 6'h00;
      else if (pre_cnt_r >= pre_last)
         pre_cnt_r <= 6'h00;
      else
         pre_cnt_r <= pre_cnt_r + 6'h01;
   end
   assign pre_tick = (prescale_select == TCSS_PSEL_EXT8) ? ext_tick_r
      : (pre_cnt_r >= pre_last);

   assign tmr2_opt_tick = tmr2_ext_clock_option ? ext_tick_r : div12_tick;
   assign tmr3_opt_tick = tmr3_ext_clock_option ? ext_tick_r : div12_tick;

   // all outputs are one-cycle enables, never derived clocks
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ticks_r <= '0;
         prescale_tick_r <= 1'b0;
      end
      else
      begin
         prescale_tick_r <= pre_tick;
         ticks_r.tmr0 <= tmr0_counter_select ? fall0
            : (tmr0_clk_sel ? 1'b1 : pre_tick);
         ticks_r.tmr1 <= tmr1_counter_select ? fall1
            : (tmr1_clk_sel ? 1'b1 : pre_tick);
         ticks_r.tmr2_low <= tmr2_low_byte_clk_sel ? 1'b1 : tmr2_opt_tick;
         ticks_r.tmr2_high <= tmr2_split_mode
            && (tmr2_high_byte_clk_sel ? 1'b1 : tmr2_opt_tick);
         ticks_r.tmr3_low <= tmr3_low_byte_clk_sel ? 1'b1 : tmr3_opt_tick;
         ticks_r.tmr3_high <= tmr3_split_mode
            && (tmr3_high_byte_clk_sel ? 1'b1 : tmr3_opt_tick);
      end
   end
   assign ticks = ticks_r;
   assign prescale_tick = prescale_tick_r;

   // helper: cycles since last prescaler tick, valid only with no write since
   logic [5:0] gap_r;
   logic clean_r;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         gap_r <= 6'h00;
         clean_r <= 1'b0;
      end
      else
      begin
         if (prescale_tick_r)
            gap_r <= 6'h01;
         else if (gap_r != TCSS_GAP_MAX)
            gap_r <= gap_r + 6'h01;
         if (sfr_wr && reg_hit)
            clean_r <= 1'b0;
         else if (prescale_tick_r)
            clean_r <= 1'b1;
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);

   div_twelve_a: assert property (prescale_tick_r && clean_r
      && prescale_select == TCSS_PSEL_DIV12 |-> gap_r == 6'h0c)
      else $error("prescaler period not twelve");
   div_four_a: assert property (prescale_tick_r && clean_r
      && prescale_select == TCSS_PSEL_DIV4 |-> gap_r == 6'h04)
      else $error("prescaler period not four");
   div_fortyeight_a: assert property (prescale_tick_r && clean_r
      && prescale_select == TCSS_PSEL_DIV48 |-> gap_r == 6'h30)
      else $error("prescaler period not forty-eight");
   ext_source_a: assert property (prescale_select == TCSS_PSEL_EXT8
      && !ext_tick_r |=> !prescale_tick_r)
      else $error("prescaler ticked without external divided tick");
   t0_system_clock_a: assert property (!tmr0_counter_select && tmr0_clk_sel |=> ticks.tmr0)
      else $error("timer0 not on system clock");
   t0_counter_a: assert property (tmr0_counter_select |=> ticks.tmr0 == $past(fall0))
      else $error("timer0 counter mode not following pin edges");
   t1_prescale_a: assert property (!tmr1_counter_select && !tmr1_clk_sel
      |=> ticks.tmr1 == $past(pre_tick))
      else $error("timer1 not on prescaler tick");
   t1_counter_a: assert property (tmr1_counter_select |=> ticks.tmr1 == $past(fall1))
      else $error("timer1 counter mode not following pin edges");
   t2_low_a: assert property (!tmr2_low_byte_clk_sel && !tmr2_ext_clock_option
      |=> ticks.tmr2_low == $past(div12_tick))
      else $error("timer2 low byte not on divide by twelve");
   t2_high_a: assert property (!tmr2_split_mode |=> !ticks.tmr2_high)
      else $error("timer2 high byte ticked outside split mode");
   t3_low_a: assert property (tmr3_low_byte_clk_sel |=> ticks.tmr3_low)
      else $error("timer3 low byte not on system clock");
   t3_high_a: assert property (tmr3_split_mode && tmr3_high_byte_clk_sel
      |=> ticks.tmr3_high)
      else $error("timer3 high byte not on system clock");
   reg_read_a: assert property (sfr_rd && reg_hit
      |=> sfr_rdata == $past(timer_clock_control_r))
      else $error("clock control read data wrong");
   reg_write_a: assert property (sfr_wr && reg_hit
      |=> timer_clock_control_r == $past(sfr_wdata))
      else $error("clock control write lost");

   ext_mode_c: cover property (prescale_select == TCSS_PSEL_EXT8 && prescale_tick_r);
   t0_count_c: cover property (tmr0_counter_select && ticks.tmr0);
   split_c: cover property (tmr2_split_mode && ticks.tmr2_high && !ticks.tmr2_low);
endmodule

// ---- tb/tcss_pins_model.sv ----
// pin-side partner: event pin trains and a free-running external oscillator
`timescale 1ns/1ps
module tcss_pins_model
(
   // clock
   input wire logic mclk,
   // per-pin request for an event train
   input wire logic [1:0] ev_req,
   // pins
   output logic tmr0_event_pin,
   output logic tmr1_event_pin,
   output logic ext_osc_clk
);
   int ph = 0;
   int ec = 0;
   initial
   begin
      tmr0_event_pin = 1'b0;
      tmr1_event_pin = 1'b0;
      ext_osc_clk = 1'b0;
   end
   // oscillator at a quarter of mclk, each level two cycles
   always @(posedge mclk)
   begin
      ph <= (ph == 3) ? 0 : ph + 1;
      ext_osc_clk <= (ph < 2);
   end
   // pins toggle every two cycles: the fastest event rate the sampler must follow
   always @(posedge mclk)
   begin
      ec <= (ec == 1) ? 0 : ec + 1;
      if (ec == 1)
      begin
         tmr0_event_pin <= ev_req[0] & ~tmr0_event_pin;
         tmr1_event_pin <= ev_req[1] & ~tmr1_event_pin;
      end
   end
endmodule

// ---- tb/test_tcss_top.sv ----
// self-checking bench for timer clock source selection
`timescale 1ns/1ps
module test_tcss_top
   import tcss_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] page = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   // mode bits: counter0, counter1, ext2, ext3, split2, split3
   logic [5:0] md = 6'h00;
   logic [1:0] ev_req = 2'b00;
   wire logic tp0;
   wire logic tp1;
   wire logic osc;
   tcss_ticks_t ticks;
   logic prescale_tick;
   wire logic [6:0] v;
   logic [7:0] cfg [0:7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0c, 8'hf0, 8'h53, 8'hae};
   int n_fail = 0;
   int checks = 0;
   int seed = 40977;
   int regm = 0;
   int p;
   int c0;
   int c1;
   assign v = {ticks, prescale_tick};
   always #20 mclk = ~mclk;

   tcss_top tcss_top_i (.mclk(mclk), .rst(rst), .sfr_addr(addr), .sfr_page(page),
      .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
      .tmr0_counter_select(md[0]), .tmr1_counter_select(md[1]),
      .tmr2_ext_clock_option(md[2]), .tmr3_ext_clock_option(md[3]),
      .tmr2_split_mode(md[4]), .tmr3_split_mode(md[5]),
      .tmr0_event_pin(tp0), .tmr1_event_pin(tp1), .ext_osc_clk(osc),
      .ticks(ticks), .prescale_tick(prescale_tick));
   tcss_pins_model tcss_pins_model_i (.mclk(mclk), .ev_req(ev_req),
      .tmr0_event_pin(tp0), .tmr1_event_pin(tp1), .ext_osc_clk(osc));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wdata = d;
      page = 8'($random(seed));
      wr = 1'b1;
      @(negedge mclk);
      wr = 1'b0;
      if (a == TCSS_CLK_CTRL_ADDR)
         regm = d;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      addr = a;
      page = 8'($random(seed));
      rd = 1'b1;
      @(negedge mclk);
      rd = 1'b0;
      chk(rdata, exp);
   endtask

   // cycles between two pulses of one enable, 0 when it stays quiet
   task automatic per(input int i, output int r);
      int k;
      k = 0;
      r = 0;
      while (v[i] !== 1'b1 && k < 120)
      begin
         @(negedge mclk);
         k++;
      end
      if (k < 120)
      begin
         r = 1;
         @(negedge mclk);
         while (v[i] !== 1'b1 && r < 120)
         begin
            @(negedge mclk);
            r++;
         end
         if (r >= 120)
            r = 0;
      end
   endtask

   // reference model; external oscillator path gives 4 x 8 = 32 cycles
   function automatic int exp_per(input int i);
      int pp;
      pp = (regm[1:0] == 2'h0) ? 12 : (regm[1:0] == 2'h1) ? 4 : (regm[1:0] == 2'h2) ? 48 : 32;
      case (i)
         0: return pp;
         6: return md[0] ? 0 : (regm[2] ? 1 : pp);
         5: return md[1] ? 0 : (regm[3] ? 1 : pp);
         4: return regm[4] ? 1 : (md[2] ? 32 : 12);
         3: return !md[4] ? 0 : (regm[5] ? 1 : (md[2] ? 32 : 12));
         2: return regm[6] ? 1 : (md[3] ? 32 : 12);
         default: return !md[5] ? 0 : (regm[7] ? 1 : (md[3] ? 32 : 12));
      endcase
   endfunction

   initial
   begin
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      rd_reg(8'h8e, 8'h00);
      wr_reg(8'h8e, 8'($random(seed)));
      rd_reg(8'h8e, regm[7:0]);
      wr_reg(8'h8d, 8'hff);
      rd_reg(8'h8e, regm[7:0]);
      rd_reg(8'h8f, 8'h00);
      $display("register test done");
      foreach (cfg[k])
      begin
         md = 6'($random(seed)) & 6'h3c;
         wr_reg(8'h8e, cfg[k]);
         for (int i = 0; i < 7; i++)
         begin
            per(i, p);
            chk(p[7:0], 8'(exp_per(i)));
         end
      end
      $display("clock select test done");
      md = 6'h03;
      wr_reg(8'h8e, 8'h0c);
      per(6, p);
      chk(p[7:0], 8'h00);
      per(5, p);
      chk(p[7:0], 8'h00);
      c0 = 0;
      c1 = 0;
      for (int k = 0; k < 28; k++)
      begin
         ev_req = (k < 20) ? 2'b11 : 2'b00;
         @(negedge mclk);
         c0 += int'(v[6] === 1'b1);
         c1 += int'(v[5] === 1'b1);
      end
      chk(8'(c0), 8'h05);
      chk(8'(c1), 8'h05);
      $display("event count test done");
      end_of_test();
   end

   initial
   begin
      #2000000;
      n_fail++;
      end_of_test();
   end
endmodule
